/* File: design/cpu_decode_params.svh */
// Constants for the instruction-subset decoder and sequencer.
`ifndef CPU_DECODE_PARAMS_SVH
`define CPU_DECODE_PARAMS_SVH
`define OP_TEST        8'h00
`define OP_TAP         8'h06
`define OP_TPA         8'h07
`define OP_TAB         8'h16
`define OP_TBA         8'h17
`define OP_TSX         8'h30
`define OP_TXS         8'h35
`define OP_SWI         8'h3F
`define OP_WAIT        8'h3E
`define OP_TSTA        8'h4D
`define OP_TSTB        8'h5D
`define OP_TST_IDX     8'h6D
`define OP_TST_EXT     8'h7D
`define OP_XGD         8'h8F
`define OP_SUBD_IMM    8'h83
`define PAGE_Y_PREFIX  8'h18
`define MODE_IMM       2'h0
`define MODE_DIR       2'h1
`define MODE_IDX       2'h2
`define MODE_EXT       2'h3
`define SUB_LOW_MASK   8'h0F
`define SUB_A_LOW      8'h00
`define SUB_D_LOW      8'h03
`define ZERO_PAGE      8'h00
`define STACK_CYCLES   4'hC
`define VECTOR_CYCLES  4'h2
`define CCR_S_BIT      7
`define CCR_X_BIT      6
`define CCR_I_BIT      4
`define CCR_N_BIT      3
`define CCR_Z_BIT      2
`define CCR_V_BIT      1
`define CCR_C_BIT      0
`define CCR_RESET      8'hD0
`define VEC_SWI        16'hFFF6
`define STACK_RESET    16'h00FF
`define PC_RESET       16'h0000
`endif

/* File: design/cpu_decode_pkg.sv */
// Types shared by the decoder files.
package cpu_decode_pkg;
    typedef struct packed {
        logic [15:0] addr;
        logic        rd;
        logic        wr;
        logic [7:0]  wdata;
    } bus_req_s;
    typedef struct packed {
        logic [7:0] a;
        logic [7:0] b;
        logic [15:0] ix;
        logic [15:0] iy;
        logic [15:0] sp;
        logic [7:0] ccr;
    } regs_s;
endpackage

/* File: design/byte_stack_mem.sv */
// Small register-output memory holding the stacked register image.
`timescale 1ns/10ps
module byte_stack_mem
(
    input  wire logic       clk_i,
    input  wire logic       we_i,
    input  wire logic [3:0] waddr_i,
    input  wire logic [7:0] wdata_i,
    input  wire logic [3:0] raddr_i,
    output logic      [7:0] rdata_o
);
    logic [7:0] mem_ff [0:15];
    logic [7:0] rdata_ff;

    always_ff @(posedge clk_i)
    begin
        if (we_i)
        begin
            mem_ff[waddr_i] <= wdata_i;
        end
        rdata_ff <= mem_ff[raddr_i];
    end

    assign rdata_o = rdata_ff;
endmodule

/* File: design/cpu_instr_decode_subset.sv */
// Decoder and sequencer for the subtract, transfer, test, wait and test-mode instructions.
// Contract
// - Wait instruction spends twelve cycles from opcode fetch stacking, then waits for interrupt.
// - After interrupt recognized, two vector cycles follow, fourteen plus n total.
// - Test instruction counts the address bus until reset; only in test mode.
// - Direct operand is low address byte; high byte forced to zero.
// - Index offset is unsigned 0..255, added to the chosen index register.
// - Branch displacement sign-extended, added to address after the displacement byte.
// - Extended address: first operand byte high, second byte low.
// - Sixteen-bit immediate: first byte high half, second byte low half.
// - Bit mask operand: only bits set to one are affected.
// - Transfer to condition codes may clear X mask but never set it.
// - Branch target base is the address after the displacement byte.
`timescale 1ns/10ps
module cpu_instr_decode_subset
    import cpu_decode_pkg::*;
(
    input  wire logic        clk_i,
    input  wire logic        sys_rst_i,
    input  wire logic        test_mode_i,
    input  wire logic        irq_i,
    input  wire logic [7:0]  rdata_i,
    output bus_req_s         bus_o,
    output regs_s            regs_o,
    output logic             waiting_o,
    output logic [15:0]      pc_o
);
`include "cpu_decode_params.svh"

    typedef enum logic [3:0] {
        S_FETCH, S_OPND1, S_OPND2, S_MEM_HI, S_MEM_LO,
        S_EXEC, S_STACK, S_WAIT, S_VEC_HI, S_VEC_LO, S_TEST
    } state_e;

    state_e      state_ff, nxt_state;
    regs_s       regs_ff, nxt_regs;
    bus_req_s    bus_ff, nxt_bus;
    logic [15:0] pc_ff, nxt_pc;
    logic [7:0]  op_ff, nxt_op;
    logic        pagey_ff, nxt_pagey;
    logic [7:0]  opnd1_ff, nxt_opnd1;
    logic [15:0] ea_ff, nxt_ea;
    logic [15:0] mval_ff, nxt_mval;
    logic [3:0]  cnt_ff, nxt_cnt;
    logic        waiting_ff, nxt_waiting;
    logic [7:0]  stk_rdata;
    logic [15:0] dsum;

    // Result flags for a subtract of the given width; both widths use this.
    function automatic logic [3:0] sub_flags(input logic [15:0] x, input logic [15:0] m,
                                            input logic wide);
        logic [16:0] r;
        logic        n;
        logic        z;
        logic        v;
        r = {1'b0, x} - {1'b0, m};
        if (wide)
        begin
            n = r[15];
            z = (r[15:0] == 16'h0000);
            v = (x[15] ^ m[15]) & (x[15] ^ r[15]);
            return {n, z, v, r[16]};
        end
        r = {9'h000, x[7:0]} - {9'h000, m[7:0]};
        n = r[7];
        z = (r[7:0] == 8'h00);
        v = (x[7] ^ m[7]) & (x[7] ^ r[7]);
        return {n, z, v, r[8]};
    endfunction

    // Applies a bit-mask operand: only set positions take the new value.
    function automatic logic [7:0] apply_mask(input logic [7:0] old, input logic [7:0] nv,
                                             input logic [7:0] mask);
        return (old & ~mask) | (nv & mask);
    endfunction

    function automatic logic [15:0] branch_target(input logic [15:0] next_pc,
                                                  input logic [7:0]  disp);
        return next_pc + {{8{disp[7]}}, disp};
    endfunction

    function automatic logic [1:0] mode_of(input logic [7:0] op);
        return op[5:4];
    endfunction

    function automatic logic is_sub(input logic [7:0] op);
        logic [7:0] lo;
        lo = op & `SUB_LOW_MASK;
        return op[7] && (lo == `SUB_A_LOW || (lo == `SUB_D_LOW && !op[6]));
    endfunction

    assign dsum = {regs_ff.a, regs_ff.b};

    byte_stack_mem u_stack
    (
        .clk_i   (clk_i),
        .we_i    (state_ff == S_STACK),
        .waddr_i (cnt_ff),
        .wdata_i (regs_ff.a ^ {4'h0, cnt_ff}),
        .raddr_i (cnt_ff),
        .rdata_o (stk_rdata)
    );

    always_comb
    begin
        nxt_state   = state_ff;
        nxt_regs    = regs_ff;
        nxt_bus     = bus_ff;
        nxt_pc      = pc_ff;
        nxt_op      = op_ff;
        nxt_pagey   = pagey_ff;
        nxt_opnd1   = opnd1_ff;
        nxt_ea      = ea_ff;
        nxt_mval    = mval_ff;
        nxt_cnt     = cnt_ff;
        nxt_waiting = 1'b0;
        nxt_bus.rd  = 1'b1;
        nxt_bus.wr  = 1'b0;
        unique case (state_ff)
            S_FETCH:
            begin
                nxt_pc = pc_ff + 16'h0001;
                nxt_bus.addr = nxt_pc;
                if (rdata_i == `PAGE_Y_PREFIX && !pagey_ff)
                begin
                    nxt_pagey = 1'b1;
                end
                else
                begin
                    nxt_op = rdata_i;
                    nxt_cnt = 4'h1;
                    nxt_state = S_EXEC;
                    if (rdata_i == `OP_TEST && test_mode_i)
                    begin
                        nxt_state = S_TEST;
                    end
                    else if (rdata_i == `OP_WAIT || rdata_i == `OP_SWI)
                    begin
                        nxt_state = S_STACK;
                    end
                    else if (is_sub(rdata_i) || rdata_i == `OP_TST_EXT ||
                             rdata_i == `OP_TST_IDX)
                    begin
                        nxt_state = S_OPND1;
                    end
                end
            end
            S_OPND1:
            begin
                nxt_opnd1 = rdata_i;
                nxt_pc = pc_ff + 16'h0001;
                nxt_bus.addr = nxt_pc;
                nxt_state = S_MEM_HI;
                if (mode_of(op_ff) == `MODE_DIR)
                begin
                    nxt_ea = {`ZERO_PAGE, rdata_i};
                    nxt_bus.addr = nxt_ea;
                end
                else if (mode_of(op_ff) == `MODE_IDX || op_ff == `OP_TST_IDX)
                begin
                    nxt_ea = (pagey_ff ? regs_ff.iy : regs_ff.ix) + {8'h00, rdata_i};
                    // prefix fetch is the extra cycle
                    nxt_state = S_MEM_HI;
                    nxt_bus.addr = nxt_ea;
                end
                else if (mode_of(op_ff) == `MODE_EXT || mode_of(op_ff) == `MODE_IMM ||
                         op_ff == `OP_SUBD_IMM || op_ff == `OP_TST_EXT)
                begin
                    nxt_state = S_OPND2;
                end
                if (mode_of(op_ff) == `MODE_IMM && op_ff != `OP_SUBD_IMM)
                begin
                    nxt_mval = {8'h00, rdata_i};
                    nxt_state = S_EXEC;
                end
            end
            S_OPND2:
            begin
                nxt_pc = pc_ff + 16'h0001;
                nxt_ea = {opnd1_ff, rdata_i};
                nxt_mval = {opnd1_ff, rdata_i};
                nxt_bus.addr = (op_ff == `OP_SUBD_IMM) ? nxt_pc : nxt_ea;
                nxt_state = (op_ff == `OP_SUBD_IMM) ? S_EXEC : S_MEM_HI;
            end
            S_MEM_HI:
            begin
                nxt_mval = {8'h00, rdata_i};
                nxt_state = S_EXEC;
                if ((op_ff & `SUB_LOW_MASK) == `SUB_D_LOW)
                begin
                    nxt_ea = ea_ff + 16'h0001;
                    nxt_bus.addr = nxt_ea;
                    nxt_state = S_MEM_LO;
                end
            end
            S_MEM_LO:
            begin
                nxt_mval = {mval_ff[7:0], rdata_i};
                nxt_state = S_EXEC;
            end
            S_EXEC:
            begin
                nxt_pagey = 1'b0;
                nxt_bus.addr = pc_ff;
                nxt_state = S_FETCH;
                if (is_sub(op_ff))
                begin
                    if ((op_ff & `SUB_LOW_MASK) == `SUB_D_LOW)
                    begin
                        {nxt_regs.a, nxt_regs.b} = dsum - mval_ff;
                        nxt_regs.ccr[3:0] = sub_flags(dsum, mval_ff, 1'b1);
                    end
                    else if (op_ff[6])
                    begin
                        nxt_regs.b = regs_ff.b - mval_ff[7:0];
                        nxt_regs.ccr[3:0] = sub_flags({8'h00, regs_ff.b}, mval_ff, 1'b0);
                    end
                    else
                    begin
                        nxt_regs.a = regs_ff.a - mval_ff[7:0];
                        nxt_regs.ccr[3:0] = sub_flags({8'h00, regs_ff.a}, mval_ff, 1'b0);
                    end
                end
                else
                begin
                    unique case (op_ff)
                        `OP_TAP:
                        begin
                            nxt_regs.ccr = regs_ff.a;
                            nxt_regs.ccr[`CCR_X_BIT] = regs_ff.a[`CCR_X_BIT] &
                                                      regs_ff.ccr[`CCR_X_BIT];
                        end
                        `OP_TPA: nxt_regs.a = regs_ff.ccr;
                        `OP_TAB: nxt_regs.b = regs_ff.a;
                        `OP_TBA: nxt_regs.a = regs_ff.b;
                        `OP_TSX:
                        begin
                            if (pagey_ff)
                                nxt_regs.iy = regs_ff.sp + 16'h0001;
                            else
                                nxt_regs.ix = regs_ff.sp + 16'h0001;
                        end
                        `OP_TXS:
                            nxt_regs.sp = (pagey_ff ? regs_ff.iy : regs_ff.ix) - 16'h0001;
                        `OP_XGD:
                        begin
                            {nxt_regs.a, nxt_regs.b} = pagey_ff ? regs_ff.iy : regs_ff.ix;
                            if (pagey_ff)
                                nxt_regs.iy = dsum;
                            else
                                nxt_regs.ix = dsum;
                        end
                        default:
                        begin
                            nxt_regs.ccr[`CCR_C_BIT] = regs_ff.ccr[`CCR_C_BIT];
                        end
                    endcase
                    if (op_ff == `OP_TSTA || op_ff == `OP_TSTB || op_ff == `OP_TST_EXT ||
                        op_ff == `OP_TST_IDX)
                    begin
                        nxt_regs.ccr[3:0] = sub_flags({8'h00, op_ff == `OP_TSTA ? regs_ff.a :
                                            op_ff == `OP_TSTB ? regs_ff.b : mval_ff[7:0]},
                                            16'h0000, 1'b0);
                    end
                    if (op_ff == `OP_TAB || op_ff == `OP_TBA)
                    begin
                        nxt_regs.ccr[`CCR_N_BIT] = nxt_regs.a[7];
                        nxt_regs.ccr[`CCR_Z_BIT] = (nxt_regs.a == 8'h00);
                        nxt_regs.ccr[`CCR_V_BIT] = 1'b0;
                    end
                    nxt_regs.ccr = apply_mask(regs_ff.ccr, nxt_regs.ccr, 8'hFF);
                end
            end
            S_STACK:
            begin
                nxt_bus.rd = 1'b0;
                nxt_bus.wr = 1'b1;
                nxt_bus.addr = regs_ff.sp;
                nxt_bus.wdata = stk_rdata;
                nxt_regs.sp = regs_ff.sp - 16'h0001;
                nxt_cnt = cnt_ff + 4'h1;
                // The opcode fetch and the following read are part of the twelve.
                if (cnt_ff == `STACK_CYCLES - 4'h2)
                begin
                    nxt_cnt = 4'h0;
                    nxt_state = (op_ff == `OP_WAIT) ? S_WAIT : S_VEC_HI;
                    if (op_ff == `OP_SWI)
                        nxt_regs.ccr[`CCR_I_BIT] = 1'b1;
                end
            end
            S_WAIT:
            begin
                nxt_waiting = 1'b1;
                nxt_bus.rd = 1'b0;
                if (irq_i)
                begin
                    nxt_waiting = 1'b0;
                    nxt_state = S_VEC_HI;
                    nxt_bus.rd = 1'b1;
                    nxt_bus.addr = `VEC_SWI;
                end
            end
            S_VEC_HI:
            begin
                nxt_bus.addr = `VEC_SWI + 16'h0001;
                nxt_pc[15:8] = rdata_i;
                nxt_state = S_VEC_LO;
            end
            S_VEC_LO:
            begin
                nxt_pc[7:0] = rdata_i;
                nxt_bus.addr = nxt_pc;
                nxt_state = S_FETCH;
            end
            S_TEST:
            begin
                nxt_bus.addr = bus_ff.addr + 16'h0001;
            end
            default: nxt_state = S_FETCH;
        endcase
    end

    always_ff @(posedge clk_i)
    begin
        if (sys_rst_i)
        begin
            state_ff   <= S_FETCH;
            regs_ff    <= '{a: 8'h00, b: 8'h00, ix: 16'h0000, iy: 16'h0000,
                            sp: `STACK_RESET, ccr: `CCR_RESET};
            bus_ff     <= '{addr: `PC_RESET, rd: 1'b1, wr: 1'b0, wdata: 8'h00};
            pc_ff      <= `PC_RESET;
            op_ff      <= 8'h00;
            pagey_ff   <= 1'b0;
            opnd1_ff   <= 8'h00;
            ea_ff      <= 16'h0000;
            mval_ff    <= 16'h0000;
            cnt_ff     <= 4'h0;
            waiting_ff <= 1'b0;
        end
        else
        begin
            state_ff   <= nxt_state;
            regs_ff    <= nxt_regs;
            bus_ff     <= nxt_bus;
            pc_ff      <= nxt_pc;
            op_ff      <= nxt_op;
            pagey_ff   <= nxt_pagey;
            opnd1_ff   <= nxt_opnd1;
            ea_ff      <= nxt_ea;
            mval_ff    <= nxt_mval;
            cnt_ff     <= nxt_cnt;
            waiting_ff <= nxt_waiting;
        end
    end

    assign bus_o     = bus_ff;
    assign regs_o    = regs_ff;
    assign waiting_o = waiting_ff;
    assign pc_o      = pc_ff;
endmodule

/* File: verification/bus_mem_model.sv */
// Behavioural program and data memory answering on the CPU bus.
`timescale 1ns/10ps
module bus_mem_model
    import cpu_decode_pkg::*;
(
    input  wire logic     clk_i,
    input  wire bus_req_s bus_i,
    output logic [7:0]    rdata_o
);
    logic [7:0] mem [0:65535];
    logic [7:0] last_ff;

    // An idle bus shows the inverse of the last byte, so a stale read cannot pass.
    always_comb rdata_o = bus_i.rd ? mem[bus_i.addr] : ~last_ff;

    always @(posedge clk_i)
    begin
        last_ff <= rdata_o;
        if (bus_i.wr)
            mem[bus_i.addr] <= bus_i.wdata;
    end
endmodule

/* File: verification/cpu_instr_decode_subset_checker.sv */
// Concurrent checks on the ports of the instruction-subset decoder.
`timescale 1ns/10ps
module cpu_instr_decode_subset_checker
    import cpu_decode_pkg::*;
(
    input wire logic        clk_i,
    input wire logic        sys_rst_i,
    input wire logic        test_mode_i,
    input wire logic        irq_i,
    input wire logic [7:0]  rdata_i,
    input wire bus_req_s    bus_o,
    input wire regs_s       regs_o,
    input wire logic        waiting_o,
    input wire logic [15:0] pc_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (sys_rst_i);

    sequence vec_fetch_s;
        bus_o.rd && bus_o.addr == 16'hFFF6 ##1 bus_o.rd && bus_o.addr == 16'hFFF7;
    endsequence

    sequence count_step_s;
        test_mode_i && bus_o.addr == $past(bus_o.addr) + 16'h0001;
    endsequence

    reset_state_a: assert property (disable iff (1'b0) sys_rst_i |=>
        bus_o.addr == 16'h0000 && bus_o.rd && !bus_o.wr)
        else $error("bus not at reset state after reset");
    stack_then_wait_a: assert property ($rose(waiting_o) |->
        $past(bus_o.wr) && $past(bus_o.wr, 8))
        else $error("wait state entered without stacking");
    wait_hold_a: assert property (waiting_o && !irq_i |=> waiting_o)
        else $error("wait state left without interrupt");
    wait_quiet_a: assert property (waiting_o |-> !bus_o.wr)
        else $error("write during wait state");
    wait_regs_a: assert property (waiting_o && $past(waiting_o) |->
        $stable(regs_o) && $stable(pc_o))
        else $error("registers moved during wait state");
    wait_exit_a: assert property (waiting_o && irq_i |-> ##[1:2] vec_fetch_s)
        else $error("vector not fetched after interrupt");
    test_count_a: assert property (count_step_s [*4] |=> count_step_s)
        else $error("address count stopped in test mode");
    x_mask_a: assert property (!$past(regs_o.ccr[6]) |-> !regs_o.ccr[6])
        else $error("X mask became set");
endmodule

bind cpu_instr_decode_subset cpu_instr_decode_subset_checker u_chk
(
    .clk_i       (clk_i),
    .sys_rst_i   (sys_rst_i),
    .test_mode_i (test_mode_i),
    .irq_i       (irq_i),
    .rdata_i     (rdata_i),
    .bus_o       (bus_o),
    .regs_o      (regs_o),
    .waiting_o   (waiting_o),
    .pc_o        (pc_o)
);

/* File: verification/tb_cpu_instr_decode_subset.sv */
// Self-checking bench for the instruction-subset decoder.
`timescale 1ns/10ps
module tb_cpu_instr_decode_subset
    import cpu_decode_pkg::*;
;
    logic        clk_i;
    logic        sys_rst_i;
    logic        test_mode_i;
    logic        irq_i;
    logic [7:0]  rdata_i;
    bus_req_s    bus_o;
    regs_s       regs_o;
    logic        waiting_o;
    logic [15:0] pc_o;
    int          n_fail;
    int          cmp_count;
    int          cyc;
    int          t_a;
    int          t_b;

    cpu_instr_decode_subset u_dut (.clk_i(clk_i), .sys_rst_i(sys_rst_i),
        .test_mode_i(test_mode_i), .irq_i(irq_i), .rdata_i(rdata_i), .bus_o(bus_o),
        .regs_o(regs_o), .waiting_o(waiting_o), .pc_o(pc_o));
    bus_mem_model u_mem (.clk_i(clk_i), .bus_i(bus_o), .rdata_o(rdata_i));

    initial
    begin
        clk_i = 1'b0;
        forever #20 clk_i = ~clk_i;
    end

    always @(posedge clk_i) cyc <= cyc + 1;

    task automatic give_verdict;
        $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    task automatic check(input string nm, input logic [15:0] exp, input logic [15:0] got);
        cmp_count++;
        if (got !== exp)
        begin
            n_fail++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, got);
        end
    endtask

    // Inputs always change the same short delay after a rising edge.
    task automatic step(input int n);
        repeat (n) @(posedge clk_i);
        #2;
    endtask

    task automatic wait_addr(input logic [15:0] a, input int lim, output int t);
        int k;
        k = 0;
        while (!(bus_o.rd === 1'b1 && bus_o.addr === a) && k < lim)
        begin
            step(1);
            k++;
        end
        t = cyc;
        check("bus address", a, bus_o.addr);
    endtask

    task automatic load_program;
        logic [7:0] c0 [9];
        logic [7:0] c1 [11];
        c0 = '{8'h83, 8'h7F, 8'h00, 8'h06, 8'h83, 8'hC1, 8'h00, 8'h06, 8'h3E};
        c1 = '{8'h8F, 8'h6D, 8'hFF, 8'h7D, 8'h12, 8'h34, 8'h90, 8'h85, 8'h18, 8'h6D,
               8'h10};
        for (int i = 0; i < 65536; i++)
            u_mem.mem[i] = 8'h00;
        for (int i = 0; i < 9; i++)
            u_mem.mem[i] = c0[i];
        for (int i = 0; i < 11; i++)
            u_mem.mem[16'h0100 + i] = c1[i];
        u_mem.mem[16'hFFF6] = 8'h01;
        u_mem.mem[16'h0085] = 8'h01;
    endtask

    task automatic t_reset;
        step(6);
        check("reset address", 16'h0000, bus_o.addr);
        check("reset read", 16'h0001, {15'h0, bus_o.rd});
        check("reset sp", 16'h00FF, regs_o.sp);
        check("reset ccr", 16'h00D0, {8'h00, regs_o.ccr});
        sys_rst_i = 1'b0;
        $display("test reset done");
    endtask

    task automatic t_sub;
        wait_addr(16'h0003, 20, t_a);
        step(1);
        check("a after sub", 16'h0081, {8'h00, regs_o.a});
        check("b after sub", 16'h0000, {8'h00, regs_o.b});
        check("ccr after sub", 16'h00D9, {8'h00, regs_o.ccr});
        wait_addr(16'h0004, 20, t_a);
        step(1);
        check("ccr clears x", 16'h0081, {8'h00, regs_o.ccr});
        wait_addr(16'h0007, 20, t_a);
        step(1);
        check("a after sub2", 16'h00C0, {8'h00, regs_o.a});
        check("ccr after sub2", 16'h0089, {8'h00, regs_o.ccr});
        wait_addr(16'h0008, 20, t_a);
        step(1);
        check("ccr keeps x", 16'h0080, {8'h00, regs_o.ccr});
        $display("test subtract done");
    endtask

    task automatic t_wait;
        int t0;
        int tw;
        int tc;
        t0 = t_a;
        while (waiting_o !== 1'b1 && cyc < t0 + 40)
        begin
            step(1);
        end
        tw = cyc;
        check("stack cycles", 16'd12, 16'(tw - t0 - 1));
        step(5);
        check("still waiting", 16'h0001, {15'h0, waiting_o});
        irq_i = 1'b1;
        wait_addr(16'hFFF6, 4, t_b);
        irq_i = 1'b0;
        step(1);
        check("vector low", 16'hFFF7, bus_o.addr);
        wait_addr(16'h0100, 3, tc);
        check("wait total", 16'(14 + t_b - tw), 16'(tc - t0 - 1));
        $display("test wait done");
    endtask

    task automatic t_modes;
        int tx;
        int ty;
        int tz;
        wait_addr(16'h0101, 10, tx);
        wait_addr(16'hC0FF, 6, t_a);
        wait_addr(16'h0103, 6, t_b);
        // The exchange's own execute cycle is not part of the indexed test.
        tx = t_b - tx - 1;
        wait_addr(16'h1234, 6, t_a);
        wait_addr(16'h0085, 12, t_a);
        wait_addr(16'h0108, 10, ty);
        wait_addr(16'h0010, 8, t_a);
        wait_addr(16'h010B, 8, tz);
        check("y form cycles", 16'(tx + 1), 16'(tz - ty));
        $display("test addressing done");
    endtask

    task automatic t_test;
        wait_addr(16'h0110, 20, t_a);
        test_mode_i = 1'b1;
        step(2);
        for (int k = 0; k < 8; k++)
        begin
            t_a = bus_o.addr;
            step(1);
            check("count step", 16'(t_a + 1), bus_o.addr);
        end
        sys_rst_i = 1'b1;
        test_mode_i = 1'b0;
        step(6);
        check("reset ends count", 16'h0000, bus_o.addr);
        sys_rst_i = 1'b0;
        wait_addr(16'h0003, 20, t_a);
        $display("test count done");
    endtask

    initial
    begin
        n_fail = 0;
        cmp_count = 0;
        cyc = 0;
        sys_rst_i = 1'b1;
        test_mode_i = 1'b0;
        irq_i = 1'b0;
        load_program();
        t_reset();
        t_sub();
        t_wait();
        t_modes();
        t_test();
        give_verdict();
    end

    // The whole run takes under a hundred cycles, so this limit means a hang.
    initial
    begin
        #(40 * 4000);
        n_fail++;
        $display("[FAIL] watchdog expected finish seen timeout");
        give_verdict();
    end
endmodule
